// >>> serdes_map.svh
/*
   constants of the ten bit serdes: widths, comma pattern, counts and reset values.
   assumes it is included by bare name, once per compile unit or guarded.
*/
`ifndef SERDES_MAP_SVH
`define SERDES_MAP_SVH

`define CHAR_BITS 10
`define COUNT_BITS 4
`define BIT_FIRST 4'h0
`define BIT_LAST 4'h9
`define COMMA_MASK 10'h07F
`define COMMA_VALUE 10'h07C
`define CHAR_RESET 10'h000
`define SIG_GOOD_COUNT 4'h8
`define SIG_COUNT_RESET 4'h0
`define TX_PARK_P 1'b1
`define TX_PARK_N 1'b0

`endif

// >>> serdes_pkg.sv
/*
   types shared by the serdes modules.
   assumes serdes_map.svh is on the include path.
*/
`include "serdes_map.svh"
`default_nettype none

package serdes_pkg;
   typedef logic [`CHAR_BITS-1:0] char_t;
   typedef logic [`COUNT_BITS-1:0] bit_count_t;
endpackage

`default_nettype wire

// >>> char_if.sv
/*
   carrier of the transmit character from the reference clock capture to the serializer.
   assumes the word is driven in the mclk domain and read in it.
*/
`default_nettype none

interface char_if;
   serdes_pkg::char_t word;
   modport src (output word);
   modport dst (input word);
endinterface

`default_nettype wire

// >>> bit_sync.sv
/*
   two flip-flop synchroniser, one stage pair per bit.
   assumes each bit is an independent level from another clock domain.
*/
`default_nettype none

module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output var logic [WIDTH-1:0] q
);
   if (WIDTH < 1) begin : g_bad_width
      $error("bit_sync width must be at least one");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta;
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            meta <= 1'b0;
            q[i] <= 1'b0;
         end else begin
            meta <= d[i];
            q[i] <= meta;
         end
      end
   end
endmodule

`default_nettype wire

// >>> char_capture.sv
/*
   input register on the reference clock and toggle handshake of the character to mclk.
   assumes ref_clock_in and mclk are unrelated; rst_n is shared and asynchronous.
*/
`include "serdes_map.svh"
`default_nettype none

module char_capture (
   input wire logic ref_clock_in,
   input wire logic mclk,
   input wire logic rst_n,
   input wire serdes_pkg::char_t tx_char,
   char_if.src cx
);
   serdes_pkg::char_t in_reg;
   serdes_pkg::char_t hold;
   logic req;
   logic req_m;
   logic ack;
   logic ack_r;

   bit_sync #(.WIDTH(1)) u_req_sync (.clk(mclk), .rst_n(rst_n), .d(req), .q(req_m));
   bit_sync #(.WIDTH(1)) u_ack_sync (.clk(ref_clock_in), .rst_n(rst_n), .d(ack), .q(ack_r));

   // input register, every rising reference edge
   always_ff @(posedge ref_clock_in or negedge rst_n) begin
      if (!rst_n) begin
         in_reg <= `CHAR_RESET;
      end else begin
         in_reg <= tx_char; // [R01]
      end
   end

   a_char_taken: assert property ( // [R01]
      @(posedge ref_clock_in) disable iff (!rst_n) 1'b1 |=> in_reg == $past(tx_char)
   ) else $error("character not captured on the reference edge");

   // hold word only changes once the previous one was taken
   always_ff @(posedge ref_clock_in or negedge rst_n) begin
      if (!rst_n) begin
         hold <= `CHAR_RESET;
         req <= 1'b0;
      end else if (req == ack_r) begin
         hold <= in_reg;
         req <= ~req;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cx.word <= `CHAR_RESET;
         ack <= 1'b0;
      end else if (req_m != ack) begin
         cx.word <= hold;
         ack <= ~ack;
      end
   end
endmodule

`default_nettype wire

// >>> ten_bit_serdes_parallel_port.sv
/*
   digital model of a ten bit serdes: serializer, loopback, deserializer with
   recovered word clocks, comma alignment and signal detection.
   assumes mclk is the serial bit clock, ref_clock_in the character clock, and the
   serial and control pins asynchronous to mclk.
*/
// What this block does
// [R01] character captured each rising reference edge
// [R02] bit zero sent first, then ascending
// [R03] ten bit clocks per character
// [R04] loopback parks output high/low, else data
// [R05] loopback feeds transmit stream to receiver
// [R06] external input used only without loopback
// [R07] complementary word clocks, twenty bits period
// [R08] new word on each word clock edge
// [R09] earliest received bit at position zero
// [R10] enable gates comma flag and realignment
// [R11] flag half period on comma pattern
// [R12] flag only in inverted clock phase
// [R13] signal present follows valid input signal
// [R14] test data output kept undriven
// [R15] comma realigned to positions zero to six
`include "serdes_map.svh"
`default_nettype none

module ten_bit_serdes_parallel_port #(
   parameter int CHAR_W = `CHAR_BITS,
   parameter logic [`COUNT_BITS-1:0] SIG_GOOD = `SIG_GOOD_COUNT
) (
   input wire logic mclk,
   input wire logic ref_clock_in,
   input wire logic rst_n,
   input wire serdes_pkg::char_t tx_char,
   input wire logic loopback_sel,
   input wire logic comma_align_en,
   input wire logic rx_serial_p,
   input wire logic rx_serial_n,
   output var logic tx_serial_p,
   output var logic tx_serial_n,
   output var serdes_pkg::char_t rx_word,
   output var logic rx_word_clock,
   output var logic rx_word_clock_inv,
   output var logic comma_flag,
   output var logic signal_present,
   output var logic tdo_out,
   output var logic tdo_oe
);
   if (CHAR_W != `CHAR_BITS || SIG_GOOD == `SIG_COUNT_RESET) begin : g_bad_param
      $error("unsupported character width or signal count");
   end

   char_if cx ();

   char_capture u_capture (
      .ref_clock_in(ref_clock_in),
      .mclk(mclk),
      .rst_n(rst_n),
      .tx_char(tx_char),
      .cx(cx.src)
   );

   logic [3:0] pins_s;
   logic loop_s;
   logic align_s;
   logic rx_p_s;
   logic rx_n_s;

   bit_sync #(.WIDTH(4)) u_pin_sync (
      .clk(mclk),
      .rst_n(rst_n),
      .d({loopback_sel, comma_align_en, rx_serial_p, rx_serial_n}),
      .q(pins_s)
   );

   assign {loop_s, align_s, rx_p_s, rx_n_s} = pins_s;

   // ---- transmit
   serdes_pkg::bit_count_t tx_cnt;
   serdes_pkg::char_t tx_shift;

   // character slot of ten bit clocks
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_cnt <= `BIT_FIRST;
      end else if (tx_cnt == `BIT_LAST) begin
         tx_cnt <= `BIT_FIRST; // [R03]
      end else begin
         tx_cnt <= tx_cnt + 1'b1;
      end
   end

   // shift out low bit first
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift <= `CHAR_RESET;
      end else if (tx_cnt == `BIT_LAST) begin
         tx_shift <= cx.word; // [R03]
      end else begin
         tx_shift <= {1'b0, tx_shift[`CHAR_BITS-1:1]}; // [R02]
      end
   end

   // serial output, parked during loopback
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_serial_p <= `TX_PARK_P;
         tx_serial_n <= `TX_PARK_N;
      end else if (loop_s) begin
         tx_serial_p <= `TX_PARK_P; // [R04]
         tx_serial_n <= `TX_PARK_N; // [R04]
      end else begin
         tx_serial_p <= tx_shift[0]; // [R04]
         tx_serial_n <= ~tx_shift[0]; // [R04]
      end
   end

   // ---- receive
   logic rx_bit;
   logic match;
   logic word_done;
   logic link_valid;
   serdes_pkg::char_t sr;
   serdes_pkg::char_t next_sr;
   serdes_pkg::bit_count_t rx_cnt;
   serdes_pkg::bit_count_t sig_cnt;

   // receive source select
   always_comb begin
      if (loop_s) begin
         rx_bit = tx_shift[0]; // [R05]
      end else begin
         rx_bit = rx_p_s; // [R06]
      end
   end

   // newest bit enters at the top, earliest ends at position zero
   assign next_sr = {rx_bit, sr[`CHAR_BITS-1:1]}; // [R09]
   assign match = (next_sr & `COMMA_MASK) == `COMMA_VALUE; // [R11]
   assign word_done = (rx_cnt == `BIT_LAST) || (align_s && match); // [R10] [R15]
   assign link_valid = loop_s || (rx_p_s != rx_n_s);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sr <= `CHAR_RESET;
      end else begin
         sr <= next_sr;
      end
   end

   // bit counter restarts at a comma when alignment is enabled
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt <= `BIT_FIRST;
      end else if (word_done) begin
         rx_cnt <= `BIT_FIRST; // [R15]
      end else begin
         rx_cnt <= rx_cnt + 1'b1;
      end
   end

   // word presented at each word clock edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word <= `CHAR_RESET;
      end else if (word_done) begin
         rx_word <= next_sr; // [R08] [R09]
      end
   end

   // word clocks toggle once per word, so period is two words
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx_word_clock <= 1'b0;
         rx_word_clock_inv <= 1'b1;
      end else if (word_done) begin
         rx_word_clock <= ~rx_word_clock; // [R07]
         rx_word_clock_inv <= rx_word_clock; // [R07] [R08]
      end
   end

   // comma flag lasts one word, only when the inverted clock rises
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         comma_flag <= 1'b0;
      end else if (!align_s) begin
         comma_flag <= 1'b0; // [R10]
      end else if (word_done) begin
         comma_flag <= match && rx_word_clock; // [R11] [R12]
      end
   end

   // signal present after a run of valid differential levels, or of cycles in loopback
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sig_cnt <= `SIG_COUNT_RESET;
         signal_present <= 1'b0;
      end else if (!link_valid) begin
         sig_cnt <= `SIG_COUNT_RESET;
         signal_present <= 1'b0; // [R13]
      end else begin
         if (sig_cnt != SIG_GOOD) begin
            sig_cnt <= sig_cnt + 1'b1;
         end
         signal_present <= sig_cnt == SIG_GOOD; // [R13]
      end
   end

   // test data output is never driven in this design
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0;
      end else begin
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0; // [R14]
      end
   end

   // ---- checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_tx_park: assert property ( // [R04]
      loop_s |=> tx_serial_p && !tx_serial_n
   ) else $error("serial output not parked in loopback");

   a_tx_data: assert property ( // [R04]
      !loop_s |=> tx_serial_p == $past(tx_shift[0]) && tx_serial_n == !tx_serial_p
   ) else $error("serial output does not follow shifter");

   a_tx_load_order: assert property ( // [R02]
      tx_cnt == `BIT_LAST |=> tx_shift == $past(cx.word) ##1
         tx_shift[0] == $past(tx_shift[1])
   ) else $error("character not sent low bit first");

   a_tx_slot_len: assert property ( // [R03]
      tx_cnt == `BIT_FIRST |=> (tx_cnt != `BIT_FIRST)[*8] ##1
         tx_cnt == `BIT_LAST ##1 tx_cnt == `BIT_FIRST
   ) else $error("character slot is not ten bit clocks");

   a_loop_source: assert property ( // [R05]
      loop_s && rx_cnt != `BIT_LAST && !(align_s && match) |=>
         sr[`CHAR_BITS-1] == $past(tx_shift[0])
   ) else $error("loopback does not feed the transmit stream");

   a_ext_source: assert property ( // [R06]
      !loop_s |=> sr[`CHAR_BITS-1] == $past(rx_p_s)
   ) else $error("external input not used in normal mode");

   a_clk_complement: assert property ( // [R07]
      rx_word_clock != rx_word_clock_inv
   ) else $error("word clocks not complementary");

   a_clk_period: assert property ( // [R07]
      ($changed(rx_word_clock) ##1 (!align_s)[*8] ##1 !align_s) |->
         $stable(rx_word_clock) ##1 $changed(rx_word_clock)
   ) else $error("word clock half period is not ten bits");

   a_word_present: assert property ( // [R08]
      word_done |=> $changed(rx_word_clock) && rx_word == $past(next_sr)
   ) else $error("word not presented with the clock edge");

   a_word_order: assert property ( // [R09]
      word_done && !loop_s |=> rx_word[`CHAR_BITS-1] == $past(rx_p_s)
   ) else $error("latest bit not at the top of the word");

   a_flag_gate: assert property ( // [R10]
      !align_s |=> !comma_flag
   ) else $error("comma flag raised while disabled");

   a_flag_pattern: assert property ( // [R11]
      $rose(comma_flag) |-> (rx_word & `COMMA_MASK) == `COMMA_VALUE
   ) else $error("comma flag without comma pattern");

   a_flag_phase: assert property ( // [R12]
      comma_flag |-> !rx_word_clock && rx_word_clock_inv
   ) else $error("comma flag outside inverted clock phase");

   a_comma_align: assert property ( // [R15]
      align_s && match |=> rx_cnt == `BIT_FIRST &&
         (rx_word & `COMMA_MASK) == `COMMA_VALUE
   ) else $error("word boundary not moved to the comma");

   a_sig_lost: assert property ( // [R13]
      !link_valid |=> !signal_present
   ) else $error("signal present with invalid input");

   a_sig_rise: assert property ( // [R13]
      $rose(signal_present) |-> $past(link_valid) && $past(link_valid, 2)
   ) else $error("signal present without a run of valid input");

   a_keep_align: assert property ( // [R10]
      !align_s && word_done |-> rx_cnt == `BIT_LAST
   ) else $error("word boundary moved while alignment disabled");

   a_flag_hold: assert property ( // [R11]
      comma_flag && align_s && !word_done |=> comma_flag
   ) else $error("comma flag dropped inside its word");

   a_tdo_idle: assert property ( // [R14]
      !tdo_oe && !tdo_out
   ) else $error("test data output driven");
endmodule

`default_nettype wire

// >>> serdes_link_model.sv
/*
   link-layer controller model on the parallel side of the serdes.
   assumes send_char is set by the bench and the word clocks come from the design.
*/
`default_nettype none

module serdes_link_model (
   input wire logic mclk,
   input wire logic ref_clock_in,
   input wire logic rst_n,
   input wire serdes_pkg::char_t send_char,
   input wire serdes_pkg::char_t rx_word,
   input wire logic rx_word_clock,
   input wire logic rx_word_clock_inv,
   output var serdes_pkg::char_t tx_char,
   output var serdes_pkg::char_t last_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] clk_prev;

   // character changes on the falling reference edge, clear of the capture edge
   always_ff @(negedge ref_clock_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_char <= 10'h000;
      end else begin
         tx_char <= send_char;
      end
   end

   // word clock rise seen one mclk later, so the word it marks is settled
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         clk_prev <= 2'b01;
         last_word <= 10'h000;
      end else begin
         clk_prev <= {rx_word_clock, rx_word_clock_inv};
         if ((rx_word_clock && !clk_prev[1]) || (rx_word_clock_inv && !clk_prev[0])) begin
            last_word <= rx_word;
         end
      end
   end
endmodule

`default_nettype wire

// >>> ten_bit_serdes_parallel_port_tb_top.sv
/*
   self-checking bench of the ten bit serdes.
   assumes the design files and serdes_link_model are compiled first.
*/
`default_nettype none

module ten_bit_serdes_parallel_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic ref_clock_in = 1'b0;
   logic rst_n = 1'b0;
   logic loopback_sel = 1'b0;
   logic comma_align_en = 1'b1;
   logic rx_serial_p = 1'b0;
   logic rx_serial_n = 1'b1;
   logic rx_bad = 1'b0;
   logic slip = 1'b0;
   serdes_pkg::char_t rx_pat = 10'h2FC;
   serdes_pkg::char_t send_char = 10'h2FC;
   serdes_pkg::char_t tx_char, rx_word, last_word;
   logic tx_serial_p, tx_serial_n, rx_word_clock, rx_word_clock_inv;
   logic comma_flag, signal_present, tdo_out, tdo_oe, seen;
   logic [19:0] bits;
   int n_fail = 0;
   int comparisons = 0;
   int rx_bit = 0;
   int i, k, hits;

   always #10 mclk = ~mclk;
   always #32 ref_clock_in = ~ref_clock_in;

   // far-end serial stream, earliest bit is bit zero
   always @(negedge mclk) begin
      rx_serial_p <= rx_pat[rx_bit];
      rx_serial_n <= rx_bad ? rx_pat[rx_bit] : ~rx_pat[rx_bit];
      rx_bit <= slip ? rx_bit : ((rx_bit == 9) ? 0 : rx_bit + 1);
   end

   ten_bit_serdes_parallel_port #(.SIG_GOOD(4'h2)) ten_bit_serdes_parallel_port_inst (
      .mclk(mclk), .ref_clock_in(ref_clock_in), .rst_n(rst_n), .tx_char(tx_char),
      .loopback_sel(loopback_sel), .comma_align_en(comma_align_en),
      .rx_serial_p(rx_serial_p), .rx_serial_n(rx_serial_n), .tx_serial_p(tx_serial_p),
      .tx_serial_n(tx_serial_n), .rx_word(rx_word), .rx_word_clock(rx_word_clock),
      .rx_word_clock_inv(rx_word_clock_inv), .comma_flag(comma_flag),
      .signal_present(signal_present), .tdo_out(tdo_out), .tdo_oe(tdo_oe)
   );

   serdes_link_model serdes_link_model_inst (
      .mclk(mclk), .ref_clock_in(ref_clock_in), .rst_n(rst_n), .send_char(send_char),
      .rx_word(rx_word),
      .rx_word_clock(rx_word_clock), .rx_word_clock_inv(rx_word_clock_inv),
      .tx_char(tx_char), .last_word(last_word)
   );

   task automatic end_sim();
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bound(input string what, input int n, input int lim);
      check(what, 10'(n < lim), 10'h001);
      if (n >= lim) begin
         end_sim();
      end
   endtask

   task automatic wait_word(input string what, input logic [9:0] exp);
      int n;
      for (n = 0; n < 400 && last_word !== exp; n++) @(negedge mclk);
      bound(what, n, 400);
   endtask

   initial begin
      repeat (4) @(negedge mclk);
      check("tx_reset", {tx_serial_p, tx_serial_n}, 10'h002);
      check("clk_reset", {rx_word_clock, rx_word_clock_inv}, 10'h001);
      check("tdo_reset", {tdo_out, tdo_oe}, 10'h000);
      rst_n = 1'b1;
      wait_word("rx_word_ext", 10'h2FC);
      check("sig_present", signal_present, 10'h001);
      check("clk_inv", 10'(rx_word_clock ^ rx_word_clock_inv), 10'h001);
      seen = rx_word_clock;
      for (i = 0; i < 30 && rx_word_clock === seen; i++) @(negedge mclk);
      bound("clk_wait", i, 30);
      for (k = 0; k < 30 && rx_word_clock !== seen; k++) @(negedge mclk);
      check("half_period", 10'(k), 10'h00A);
      check("last_word", last_word, 10'h2FC);
      for (i = 0; i < 60 && comma_flag !== 1'b1; i++) @(negedge mclk);
      bound("flag_wait", i, 60);
      check("flag_phase", rx_word_clock_inv, 10'h001);
      check("flag_word", rx_word & 10'h07F, 10'h07C);
      for (k = 0; k < 30 && comma_flag === 1'b1; k++) @(negedge mclk);
      check("flag_len", 10'(k), 10'h00A);
      comma_align_en = 1'b0;
      hits = 0;
      repeat (5) @(negedge mclk);
      // one repeated far-end bit moves the stream one bit later
      @(posedge mclk);
      slip = 1'b1;
      @(posedge mclk);
      slip = 1'b0;
      repeat (40) begin
         @(negedge mclk);
         if (comma_flag !== 1'b0) hits++;
      end
      check("flag_off", 10'(hits), 10'h000);
      check("kept_align", rx_word, 10'h1F9);
      comma_align_en = 1'b1;
      wait_word("realign", 10'h2FC);
      hits = 0;
      for (i = 0; i < 20; i++) begin
         @(negedge mclk);
         bits[i] = tx_serial_p;
         if (tx_serial_n !== ~tx_serial_p) hits++;
      end
      check("tx_n_inv", 10'(hits), 10'h000);
      seen = 1'b0;
      for (k = 0; k < 10; k++) if (bits[k +: 10] === 10'h2FC) seen = 1'b1;
      check("tx_order", seen, 10'h001);
      rx_bad = 1'b1;
      send_char = 10'h17C;
      loopback_sel = 1'b1;
      wait_word("rx_word_loop", 10'h17C);
      check("tx_park", {tx_serial_p, tx_serial_n}, 10'h002);
      check("sig_loop", signal_present, 10'h001);
      loopback_sel = 1'b0;
      for (i = 0; i < 40 && signal_present !== 1'b0; i++) @(negedge mclk);
      bound("sig_lost", i, 40);
      check("tdo_idle", {tdo_out, tdo_oe}, 10'h000);
      end_sim();
   end
endmodule

`default_nettype wire
